// ==== logic/mtu_regs.vh ====
// Register map, field positions, reset values and encodings of the translation unit
`ifndef MTU_REGS_VH
`define MTU_REGS_VH

// Coprocessor register numbers
`define MTU_REG_CTRL 4'h1
`define MTU_REG_TBASE 4'h2
`define MTU_REG_DOM 4'h3
`define MTU_REG_FSTAT 4'h5
`define MTU_REG_FADDR 4'h6

// Control register fields
`define MTU_CTRL_M_BIT 0
`define MTU_CTRL_S_BIT 8
`define MTU_CTRL_R_BIT 9

// Reset values
`define MTU_CTRL_RST 32'h0000_0000
`define MTU_TBASE_RST 32'h0000_0000
`define MTU_DOM_RST 32'h0000_0000
`define MTU_FSTAT_RST 8'h00
`define MTU_FADDR_RST 32'h0000_0000

// Table base keeps bits 31:14 only
`define MTU_TBASE_MASK 32'hffff_c000

// Fault status: bits 7:4 domain, 3:1 type, bit 0 set for internal faults
`define MTU_FS_SEC_TRANS 4'h5
`define MTU_FS_PAGE_TRANS 4'h7
`define MTU_FS_SEC_DOM 4'h9
`define MTU_FS_PAGE_DOM 4'hb
`define MTU_FS_SEC_PERM 4'hd
`define MTU_FS_PAGE_PERM 4'hf
`define MTU_FS_EXT_L1 4'hc
`define MTU_FS_EXT_L2 4'he

// Descriptor type field, bits 1:0
`define MTU_L1_FAULT 2'b00
`define MTU_L1_PAGE 2'b01
`define MTU_L1_SECTION 2'b10
`define MTU_L2_FAULT 2'b00
`define MTU_L2_LARGE 2'b01
`define MTU_L2_SMALL 2'b10

// Entry size codes held in the buffer
`define MTU_SZ_SECTION 2'b01
`define MTU_SZ_LARGE 2'b10
`define MTU_SZ_SMALL 2'b11

// Domain rights codes
`define MTU_DOM_NONE 2'b00
`define MTU_DOM_CLIENT 2'b01
`define MTU_DOM_MANAGER 2'b11

`endif

// ==== logic/mtu_translation_unit.v ====
// Address translation unit: lookaside buffer, access checks, table walker, coprocessor regs
//
// Behaviour
// - Each core address is translated and its access checked for permission.
// - One-megabyte section mappings are supported beside page mappings.
// - Small 4kB and large 64kB pages supported, a large page in one entry.
// - Four sub-pages each carry their own permission field (1kB or 16kB).
// - Domain rights register holds sixteen 2-bit fields, one per domain.
// - Buffer holds 64 entries and feeds the access check logic.
// - Hit drives physical address if permitted, otherwise aborts the core.
// - Miss starts a table walk in memory that then refills the buffer.
// - Refill victim chosen by a round-robin pointer stepping through all entries.
// - With translation off, the state after reset, virtual address passes unchanged.
// - All configuration registers are 32 bits, written by coprocessor transfers; reads of them return zero.
// - On a recorded fault, status bits 7:4 hold the accessed domain, or zero on a level one walk fault.
// - Status bits 3:1 give access type; bit 0 tells internal from external.
// - Any write to the status register flushes the whole buffer, data ignored.
// - On a recorded fault the address register captures the faulting address.
// - A write to the address register purges the matching buffer entry.
// - Status and address registers update on data faults, never on prefetch.
// - Walks start with level one; pages need a second level fetch.
// - Level one address is base bits 31:14 joined with address 31:20.
// - Level one type: 00 fault, 01 page table, 10 section, 11 reserved.
`timescale 1ns/1ns
`include "mtu_regs.vh"

module mtu_translation_unit #(
    parameter ENTRIES = 64,
    parameter IDX_W = 6
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire srst_i,
    // Core access request
    input wire cpu_req_i,
    input wire [31:0] cpu_vaddr_i,
    input wire cpu_write_i,
    input wire cpu_user_i,
    input wire cpu_data_i,
    output wire cpu_ready_o,
    output reg cpu_abort_o,
    output reg [31:0] cpu_paddr_o,
    // Table walk memory port
    output reg walk_req_o,
    output reg [31:0] walk_addr_o,
    input wire walk_ack_i,
    input wire walk_err_i,
    input wire [31:0] walk_rdata_i,
    // Coprocessor register transfers
    input wire cp_wr_i,
    input wire cp_rd_i,
    input wire [3:0] cp_reg_i,
    input wire [31:0] cp_wdata_i,
    output reg [31:0] cp_rdata_o,
    output reg cp_rvalid_o
);
    localparam S_LOOK = 4'b0001;
    localparam S_L1 = 4'b0010;
    localparam S_L2 = 4'b0100;
    localparam S_RESP = 4'b1000;
    // Configuration and fault registers
    reg [31:0] control_config;
    reg [31:0] table_base_pointer;
    reg [31:0] domain_rights;
    reg [7:0] fault_status_reg;
    reg [31:0] fault_address_reg;
    // Buffer storage; only the valid bits need a reset value
    reg [ENTRIES-1:0] e_valid;
    reg [19:0] e_vtag [0:ENTRIES-1];
    reg [19:0] e_pbase [0:ENTRIES-1];
    reg [1:0] e_size [0:ENTRIES-1];
    reg [3:0] e_dom [0:ENTRIES-1];
    reg [7:0] e_ap [0:ENTRIES-1];
    reg [IDX_W-1:0] repl_ptr;
    reg [3:0] state;
    reg [3:0] walk_dom;
    wire mmu_on = control_config[`MTU_CTRL_M_BIT];
    wire bit_s = control_config[`MTU_CTRL_S_BIT];
    wire bit_r = control_config[`MTU_CTRL_R_BIT];
    wire [31:0] va = cpu_vaddr_i;
    wire cp_wr_stat = cp_wr_i && (cp_reg_i == `MTU_REG_FSTAT);
    wire cp_wr_purge = cp_wr_i && (cp_reg_i == `MTU_REG_FADDR);
    // Held request is answered in the response state only, so a walk keeps the core stalled
    assign cpu_ready_o = (state == S_RESP);
    // Match every entry against the core address and the purge address
    wire [ENTRIES-1:0] hit_vec;
    wire [ENTRIES-1:0] purge_vec;
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g = g + 1) begin : g_ent
            wire is_sec = (e_size[g] == `MTU_SZ_SECTION);
            wire is_small = (e_size[g] == `MTU_SZ_SMALL);
            // Section compares 31:20, large page 31:16, small page 31:12
            assign hit_vec[g] = e_valid[g] && (e_vtag[g][19:8] == va[31:20]) &&
                (is_sec || (e_vtag[g][7:4] == va[19:16])) &&
                (!is_small || (e_vtag[g][3:0] == va[15:12]));
            assign purge_vec[g] = e_valid[g] && (e_vtag[g][19:8] == cp_wdata_i[31:20]) &&
                (is_sec || (e_vtag[g][7:4] == cp_wdata_i[19:16])) &&
                (!is_small || (e_vtag[g][3:0] == cp_wdata_i[15:12]));
        end
    endgenerate
    // Pick the hitting entry; refill never creates duplicates, so any match serves
    reg hit_any;
    reg [IDX_W-1:0] hit_idx;
    integer i;
    always @* begin
        hit_any = 1'b0;
        hit_idx = {IDX_W{1'b0}};
        for (i = 0; i < ENTRIES; i = i + 1) begin
            if (hit_vec[i]) begin
                hit_any = 1'b1;
                hit_idx = i[IDX_W-1:0];
            end
        end
    end
    wire [1:0] h_size = e_size[hit_idx];
    wire [19:0] h_pbase = e_pbase[hit_idx];
    wire [3:0] h_dom = e_dom[hit_idx];
    wire [7:0] h_ap = e_ap[hit_idx];
    wire h_sec = (h_size == `MTU_SZ_SECTION);
    // Physical address from the entry base and the page offset
    reg [31:0] hit_paddr;
    always @* begin
        case (h_size)
            `MTU_SZ_SECTION: hit_paddr = {h_pbase[19:8], va[19:0]};
            `MTU_SZ_LARGE: hit_paddr = {h_pbase[19:4], va[15:0]};
            default: hit_paddr = {h_pbase, va[11:0]};
        endcase
    end
    // Sub-page permission select: 16kB quarters of a large page, 1kB of a small one
    reg [1:0] h_subap;
    always @* begin
        case (h_size)
            `MTU_SZ_LARGE: h_subap = h_ap[{va[15:14], 1'b0} +: 2];
            `MTU_SZ_SMALL: h_subap = h_ap[{va[11:10], 1'b0} +: 2];
            default: h_subap = h_ap[1:0];
        endcase
    end
    function ap_ok;
        input [1:0] ap;
        input s;
        input r;
        input user;
        input wr;
        begin
            if (s && r) begin
                ap_ok = 1'b0;
            end else begin
                case (ap)
                    2'b00: ap_ok = !wr && ((s && !user) || r);
                    2'b01: ap_ok = !user;
                    2'b10: ap_ok = !user || !wr;
                    default: ap_ok = 1'b1;
                endcase
            end
        end
    endfunction
    // Domain rights come first; permission bits only matter for client domains
    wire [1:0] h_rights = domain_rights[{h_dom, 1'b0} +: 2];
    reg acc_ok;
    reg [3:0] acc_fs;
    always @* begin
        acc_ok = 1'b0;
        acc_fs = h_sec ? `MTU_FS_SEC_DOM : `MTU_FS_PAGE_DOM;
        case (h_rights)
            `MTU_DOM_MANAGER: acc_ok = 1'b1;
            `MTU_DOM_CLIENT: begin
                acc_ok = ap_ok(h_subap, bit_s, bit_r, cpu_user_i, cpu_write_i);
                acc_fs = h_sec ? `MTU_FS_SEC_PERM : `MTU_FS_PAGE_PERM;
            end
            default: acc_ok = 1'b0;
        endcase
    end

    // Walk result decode; reserved descriptor types are treated as translation faults
    wire [31:0] d = walk_rdata_i;
    reg refill_we;
    reg [1:0] ref_size;
    reg [19:0] ref_pbase;
    reg [3:0] ref_dom;
    reg [7:0] ref_ap;
    reg walk_fault;
    reg [3:0] walk_fs;
    reg [3:0] walk_fdom;
    always @* begin
        refill_we = 1'b0;
        ref_size = `MTU_SZ_SMALL;
        ref_pbase = d[31:12];
        ref_dom = walk_dom;
        ref_ap = d[11:4];
        walk_fault = 1'b0;
        walk_fs = `MTU_FS_SEC_TRANS;
        walk_fdom = walk_dom;
        if (walk_ack_i && (state == S_L1)) begin
            if (walk_err_i) begin
                walk_fault = 1'b1;
                walk_fs = `MTU_FS_EXT_L1;
                walk_fdom = 4'h0;
            end else if (d[1:0] == `MTU_L1_SECTION) begin
                refill_we = 1'b1;
                ref_size = `MTU_SZ_SECTION;
                ref_pbase = {d[31:20], 8'h00};
                ref_dom = d[8:5];
                ref_ap = {4{d[11:10]}};
            end else if (d[1:0] != `MTU_L1_PAGE) begin
                walk_fault = 1'b1;
                walk_fs = `MTU_FS_SEC_TRANS;
                walk_fdom = 4'h0;
            end
        end else if (walk_ack_i && (state == S_L2)) begin
            if (walk_err_i) begin
                walk_fault = 1'b1;
                walk_fs = `MTU_FS_EXT_L2;
            end else if (d[1:0] == `MTU_L2_LARGE) begin
                refill_we = 1'b1;
                ref_size = `MTU_SZ_LARGE;
                ref_pbase = {d[31:16], 4'h0};
            end else if (d[1:0] == `MTU_L2_SMALL) begin
                refill_we = 1'b1;
                ref_size = `MTU_SZ_SMALL;
            end else begin
                walk_fault = 1'b1;
                walk_fs = `MTU_FS_PAGE_TRANS;
            end
        end
    end
    // Entry contents; written only on refill into the round-robin slot
    always @(posedge clk_sys_i) begin
        if (refill_we) begin
            e_vtag[repl_ptr] <= va[31:12];
            e_pbase[repl_ptr] <= ref_pbase;
            e_size[repl_ptr] <= ref_size;
            e_dom[repl_ptr] <= ref_dom;
            e_ap[repl_ptr] <= ref_ap;
        end
    end
    // Valid bits: a flush clears a same-cycle refill, while a purge keeps the refilled entry valid
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            e_valid <= {ENTRIES{1'b0}};
            repl_ptr <= {IDX_W{1'b0}};
        end else begin
            if (refill_we) begin
                e_valid[repl_ptr] <= 1'b1;
                repl_ptr <= repl_ptr + 1'b1;
            end
            if (cp_wr_stat) begin
                e_valid <= {ENTRIES{1'b0}};
            end else if (cp_wr_purge) begin
                e_valid <= (e_valid & ~purge_vec) |
                    (refill_we ? ({{(ENTRIES-1){1'b0}}, 1'b1} << repl_ptr) : {ENTRIES{1'b0}});
            end
        end
    end
    // Core request sequencing and table walk
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            state <= S_LOOK;
            cpu_abort_o <= 1'b0;
            cpu_paddr_o <= 32'h0000_0000;
            walk_req_o <= 1'b0;
            walk_addr_o <= 32'h0000_0000;
            walk_dom <= 4'h0;
        end else begin
            case (state)
                S_LOOK: begin
                    if (cpu_req_i) begin
                        if (!mmu_on) begin
                            cpu_paddr_o <= va;
                            cpu_abort_o <= 1'b0;
                            state <= S_RESP;
                        end else if (hit_any) begin
                            cpu_paddr_o <= acc_ok ? hit_paddr : va;
                            cpu_abort_o <= !acc_ok;
                            state <= S_RESP;
                        end else begin
                            walk_req_o <= 1'b1;
                            walk_addr_o <= {table_base_pointer[31:14], va[31:20], 2'b00};
                            state <= S_L1;
                        end
                    end
                end
                S_L1: begin
                    if (walk_ack_i) begin
                        walk_req_o <= 1'b0;
                        if (walk_fault) begin
                            cpu_abort_o <= 1'b1;
                            cpu_paddr_o <= va;
                            state <= S_RESP;
                        end else if (refill_we) begin
                            state <= S_LOOK;
                        end else begin
                            // Page table pointer: fetch the second level entry
                            walk_req_o <= 1'b1;
                            walk_addr_o <= {d[31:10], va[19:12], 2'b00};
                            walk_dom <= d[8:5];
                            state <= S_L2;
                        end
                    end
                end
                S_L2: begin
                    if (walk_ack_i) begin
                        walk_req_o <= 1'b0;
                        if (walk_fault) begin
                            cpu_abort_o <= 1'b1;
                            cpu_paddr_o <= va;
                            state <= S_RESP;
                        end else begin
                            // Relookup hits the fresh entry and runs the access check
                            state <= S_LOOK;
                        end
                    end
                end
                S_RESP: begin
                    state <= S_LOOK;
                end
                default: begin
                    state <= S_LOOK;
                end
            endcase
        end
    end
    // Fault recording happens only for data accesses
    wire hit_fault = (state == S_LOOK) && cpu_req_i && mmu_on && hit_any && !acc_ok;
    wire rec_fault = cpu_data_i && (hit_fault || walk_fault);

    // Coprocessor register file
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            control_config <= `MTU_CTRL_RST;
            table_base_pointer <= `MTU_TBASE_RST;
            domain_rights <= `MTU_DOM_RST;
            fault_status_reg <= `MTU_FSTAT_RST;
            fault_address_reg <= `MTU_FADDR_RST;
            cp_rdata_o <= 32'h0000_0000;
            cp_rvalid_o <= 1'b0;
        end else begin
            if (cp_wr_i) begin
                case (cp_reg_i)
                    `MTU_REG_CTRL: control_config <= cp_wdata_i;
                    // Low bits forced to zero since the table sits on a 16kB boundary
                    `MTU_REG_TBASE: table_base_pointer <= cp_wdata_i & `MTU_TBASE_MASK;
                    `MTU_REG_DOM: domain_rights <= cp_wdata_i;
                    default: ;
                endcase
            end
            if (rec_fault) begin
                if (hit_fault) begin
                    fault_status_reg <= {h_dom, acc_fs};
                end else begin
                    fault_status_reg <= {walk_fdom, walk_fs};
                end
                fault_address_reg <= va;
            end
            cp_rvalid_o <= cp_rd_i;
            if (cp_rd_i) begin
                case (cp_reg_i)
                    `MTU_REG_FSTAT: cp_rdata_o <= {24'h00_0000, fault_status_reg};
                    `MTU_REG_FADDR: cp_rdata_o <= fault_address_reg;
                    default: cp_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // mtu_translation_unit

// ==== test/mtu_sva.sv ====
// Port-level checker for the translation unit
`timescale 1ns/1ns
module mtu_sva (
    // Clock and reset
    input wire clk_sys_i,
    input wire srst_i,
    // Core
    input wire cpu_req_i,
    input wire [31:0] cpu_vaddr_i,
    input wire cpu_write_i,
    input wire cpu_user_i,
    input wire cpu_data_i,
    input wire cpu_ready_o,
    input wire cpu_abort_o,
    input wire [31:0] cpu_paddr_o,
    // Walk port
    input wire walk_req_o,
    input wire [31:0] walk_addr_o,
    input wire walk_ack_i,
    input wire walk_err_i,
    input wire [31:0] walk_rdata_i,
    // Coprocessor
    input wire cp_wr_i,
    input wire cp_rd_i,
    input wire [3:0] cp_reg_i,
    input wire [31:0] cp_wdata_i,
    input wire [31:0] cp_rdata_o,
    input wire cp_rvalid_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    reg on;
    reg [31:0] tbase;
    reg [31:0] far_h;
    // Shadow copies so the checks need no view inside the design
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            on <= 1'b0;
            tbase <= 32'h0;
            far_h <= 32'h0;
        end else begin
            if (cp_wr_i && cp_reg_i == 4'h1)
                on <= cp_wdata_i[0];
            if (cp_wr_i && cp_reg_i == 4'h2)
                tbase <= cp_wdata_i;
            if (cpu_ready_o && cpu_abort_o && cpu_data_i)
                far_h <= cpu_vaddr_i;
        end
    end
    a_ready_pulse: assert property (cpu_ready_o |=> !cpu_ready_o)
        else $error("ready longer than one cycle");
    a_off_pass: assert property (!on && cpu_ready_o |-> cpu_paddr_o == cpu_vaddr_i && !cpu_abort_o)
        else $error("address changed while translation off");
    a_abort_addr: assert property (cpu_ready_o && cpu_abort_o |-> cpu_paddr_o == cpu_vaddr_i)
        else $error("abort without virtual address");
    a_walk_hold: assert property (walk_req_o && !walk_ack_i |=> walk_req_o && $stable(walk_addr_o))
        else $error("fetch request dropped or moved");
    a_l1_addr: assert property ($rose(walk_req_o) |-> walk_addr_o == {tbase[31:14], cpu_vaddr_i[31:20], 2'b00})
        else $error("first fetch address wrong");
    a_walk_stall: assert property (walk_req_o |-> !cpu_ready_o)
        else $error("core answered during walk");
    a_walk_cause: assert property ($rose(walk_req_o) |-> on && cpu_req_i)
        else $error("walk without translated request");
    a_rd_answer: assert property (cp_rd_i |=> cp_rvalid_o)
        else $error("register read not answered");
    a_fault_addr: assert property (cp_rd_i && cp_reg_i == 4'h6 |=> cp_rdata_o == far_h)
        else $error("fault address readback wrong");
    c_two_level: cover property (walk_ack_i ##1 walk_req_o);
    c_abort: cover property (cpu_ready_o && cpu_abort_o);
    c_status_read: cover property (cp_rd_i && cp_reg_i == 4'h5);
endmodule // mtu_sva

// ==== test/mtu_walk_mem.sv ====
// Table memory answering the unit's descriptor fetches
`timescale 1ns/1ns
module mtu_walk_mem (
    // Clock and reset
    input wire clk_sys_i,
    input wire srst_i,
    // Fetch port
    input wire req_i,
    input wire [31:0] addr_i,
    output reg ack_o,
    output reg err_o,
    output reg [31:0] rdata_o
);
    logic [31:0] tbl [logic [31:0]];
    logic [31:0] bad = 32'hffff_ffff;
    int lat = 0;
    int cnt = 0;
    int n_fetch = 0;
    initial begin
        ack_o = 1'b0;
        err_o = 1'b0;
        rdata_o = 32'h0;
    end
    // Data lines toggle outside the ack cycle so stale words never look valid
    always @(posedge clk_sys_i) begin
        if (srst_i || !req_i || ack_o) begin
            ack_o <= 1'b0;
            cnt <= 0;
            err_o <= ~err_o;
            rdata_o <= ~rdata_o;
        end else if (cnt >= lat) begin
            ack_o <= 1'b1;
            err_o <= (addr_i == bad);
            rdata_o <= tbl.exists(addr_i) ? tbl[addr_i] : 32'h0;
            n_fetch <= n_fetch + 1;
        end else begin
            cnt <= cnt + 1;
            err_o <= ~err_o;
            rdata_o <= ~rdata_o;
        end
    end
endmodule // mtu_walk_mem

// ==== test/testbench.sv ====
// Self-checking bench for the translation unit
`timescale 1ns/1ns
module testbench;
    reg clk_sys_i, srst_i, cpu_req_i, cpu_write_i, cpu_user_i, cpu_data_i, cp_wr_i, cp_rd_i;
    reg [3:0] cp_reg_i;
    reg [31:0] cpu_vaddr_i, cp_wdata_i, va;
    wire cpu_ready_o, cpu_abort_o, cp_rvalid_o, walk_req_o, walk_ack_i, walk_err_i;
    wire [31:0] cpu_paddr_o, walk_addr_o, walk_rdata_i, cp_rdata_o;
    integer err_total, n_compared, seed, i, nf;
    reg [32:0] q_core[$];
    reg [31:0] q_reg[$];
    localparam [31:0] TB = 32'h0004_0000;
    mtu_translation_unit dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .cpu_req_i(cpu_req_i),
        .cpu_vaddr_i(cpu_vaddr_i), .cpu_write_i(cpu_write_i), .cpu_user_i(cpu_user_i),
        .cpu_data_i(cpu_data_i), .cpu_ready_o(cpu_ready_o), .cpu_abort_o(cpu_abort_o),
        .cpu_paddr_o(cpu_paddr_o), .walk_req_o(walk_req_o), .walk_addr_o(walk_addr_o),
        .walk_ack_i(walk_ack_i), .walk_err_i(walk_err_i), .walk_rdata_i(walk_rdata_i),
        .cp_wr_i(cp_wr_i), .cp_rd_i(cp_rd_i), .cp_reg_i(cp_reg_i), .cp_wdata_i(cp_wdata_i),
        .cp_rdata_o(cp_rdata_o), .cp_rvalid_o(cp_rvalid_o));
    mtu_walk_mem mem (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .req_i(walk_req_o),
        .addr_i(walk_addr_o), .ack_o(walk_ack_i), .err_o(walk_err_i), .rdata_o(walk_rdata_i));
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    task stop_test;
        begin
            if (err_total == 0 && n_compared > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task note(input ok, input [8*8-1:0] what);
        begin
            n_compared = n_compared + 1;
            if (!ok) begin
                err_total = err_total + 1;
                $display("ERROR %0t %0s mismatch", $time, what);
            end
        end
    endtask
    task chk_core(input [32:0] e);
        note({cpu_abort_o, cpu_paddr_o} === e, "core");
    endtask
    task chk_reg(input [31:0] e);
        note(cp_rdata_o === e, "register");
    endtask
    task chk_cnt(input integer e);
        note(mem.n_fetch == e, "fetches");
    endtask
    // Results are matched in order of issue; an empty queue forces a mismatch
    always @(negedge clk_sys_i) begin
        if (cpu_ready_o === 1'b1)
            chk_core(q_core.size() ? q_core.pop_front() : {33{1'bx}});
        if (cp_rvalid_o === 1'b1)
            chk_reg(q_reg.size() ? q_reg.pop_front() : {32{1'bx}});
    end
    task acc(input [31:0] v, input dat, input ab, input [31:0] pa);
        integer k;
        begin
            @(negedge clk_sys_i);
            cpu_req_i = 1'b1;
            cpu_vaddr_i = v;
            cpu_data_i = dat;
            cpu_write_i = $random(seed);
            cpu_user_i = $random(seed);
            q_core.push_back({ab, pa});
            k = 0;
            @(negedge clk_sys_i);
            while (cpu_ready_o !== 1'b1 && k < 500) begin
                @(negedge clk_sys_i);
                k = k + 1;
            end
            note(k < 500, "timeout");
            @(negedge clk_sys_i);
            cpu_req_i = 1'b0;
        end
    endtask
    task cpw(input [3:0] r, input [31:0] d);
        begin
            @(negedge clk_sys_i);
            cp_wr_i = 1'b1;
            cp_reg_i = r;
            cp_wdata_i = d;
            @(negedge clk_sys_i);
            cp_wr_i = 1'b0;
        end
    endtask
    task cpr(input [3:0] r, input [31:0] e);
        begin
            @(negedge clk_sys_i);
            cp_rd_i = 1'b1;
            cp_reg_i = r;
            q_reg.push_back(e);
            @(negedge clk_sys_i);
            cp_rd_i = 1'b0;
        end
    endtask
    function [31:0] l1a(input [31:0] v);
        l1a = {TB[31:14], v[31:20], 2'b00};
    endfunction
    function [31:0] sec(input [11:0] b, input [1:0] ap, input [3:0] d);
        sec = {b, 8'h00, ap, 1'b0, d, 5'b10010};
    endfunction
    initial begin
        #200000;
        err_total = err_total + 1;
        stop_test;
    end
    initial begin
        {err_total, n_compared, seed} = {32'd0, 32'd0, 32'd28};
        {cpu_req_i, cpu_write_i, cpu_user_i, cpu_data_i, cp_wr_i, cp_rd_i} = 6'h00;
        {cp_reg_i, cpu_vaddr_i, cp_wdata_i} = 68'h0;
        srst_i = 1'b1;
        repeat (12) @(negedge clk_sys_i);
        srst_i = 1'b0;
        cpr(4'h5, 32'h0);
        cpr(4'h6, 32'h0);
        for (i = 0; i < 4; i = i + 1) begin
            va = $random(seed);
            acc(va, 1'b1, 1'b0, va);
        end
        chk_cnt(0);
        cpw(4'h2, TB);
        cpw(4'h3, 32'h0000_0034);
        cpw(4'h1, 32'h0000_0001);
        cpr(4'h1, 32'h0);
        cpr(4'h4, 32'h0);
        mem.lat = 3;
        mem.tbl[l1a(32'h1234_5678)] = sec(12'habc, 2'b11, 4'd1);
        acc(32'h1234_5678, 1'b1, 1'b0, 32'habc4_5678);
        acc(32'h1234_0000, 1'b1, 1'b0, 32'habc4_0000);
        chk_cnt(1);
        mem.lat = 0;
        mem.tbl[l1a(32'h2000_0000)] = {22'h000401, 1'b0, 4'd1, 5'b10001};
        mem.tbl[32'h0010_0414] = {20'h77777, 8'hf3, 4'b0010};
        acc(32'h2000_5000, 1'b1, 1'b0, 32'h7777_7000);
        acc(32'h2000_5400, 1'b1, 1'b1, 32'h2000_5400);
        chk_cnt(3);
        cpr(4'h5, 32'h1f);
        cpr(4'h6, 32'h2000_5400);
        mem.tbl[l1a(32'h3001_0000)] = {22'h000800, 1'b0, 4'd1, 5'b10001};
        mem.tbl[32'h0020_0060] = {16'h5a5a, 4'h0, 8'h30, 4'b0001};
        acc(32'h3001_8abc, 1'b1, 1'b0, 32'h5a5a_8abc);
        acc(32'h3001_4abc, 1'b1, 1'b1, 32'h3001_4abc);
        chk_cnt(5);
        mem.tbl[l1a(32'h4000_0010)] = sec(12'h123, 2'b11, 4'd0);
        acc(32'h4000_0010, 1'b1, 1'b1, 32'h4000_0010);
        acc(32'h4100_0000, 1'b0, 1'b1, 32'h4100_0000);
        cpr(4'h5, 32'h09);
        cpr(4'h6, 32'h4000_0010);
        mem.tbl[l1a(32'h4300_0000)] = 32'h3;
        mem.bad = l1a(32'h4400_0000);
        for (i = 0; i < 3; i = i + 1) begin
            va = 32'h4200_0000 + (i << 24);
            acc(va, 1'b1, 1'b1, va);
            cpr(4'h5, i == 2 ? 32'h0c : 32'h05);
        end
        cpw(4'h5, $random(seed));
        nf = mem.n_fetch;
        acc(32'h1234_5678, 1'b1, 1'b0, 32'habc4_5678);
        acc(32'h2000_5000, 1'b1, 1'b0, 32'h7777_7000);
        chk_cnt(nf + 3);
        cpw(4'h6, 32'h1234_5678);
        acc(32'h2000_5000, 1'b1, 1'b0, 32'h7777_7000);
        chk_cnt(nf + 3);
        acc(32'h1234_5678, 1'b1, 1'b0, 32'habc4_5678);
        chk_cnt(nf + 4);
        cpw(4'h1, 32'h0000_0301);
        acc(32'h1234_5678, 1'b1, 1'b1, 32'h1234_5678);
        cpr(4'h5, 32'h1d);
        cpw(4'h1, 32'h0000_0001);
        cpw(4'h5, 32'h0);
        nf = mem.n_fetch;
        for (i = 0; i <= 64; i = i + 1) begin
            va = $random(seed);
            va[31:20] = i[11:0] + 12'h800;
            mem.tbl[l1a(va)] = sec(i[11:0] + 12'h900, 2'b11, 4'd2);
            mem.lat = i % 4;
            acc(va, 1'b1, 1'b0, {i[11:0] + 12'h900, va[19:0]});
        end
        chk_cnt(nf + 65);
        acc(32'h8020_0000, 1'b1, 1'b0, 32'h9020_0000);
        chk_cnt(nf + 65);
        acc(32'h8000_0000, 1'b1, 1'b0, 32'h9000_0000);
        chk_cnt(nf + 66);
        repeat (4) @(negedge clk_sys_i);
        stop_test;
    end
endmodule // testbench
bind mtu_translation_unit mtu_sva chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .cpu_req_i(cpu_req_i), .cpu_vaddr_i(cpu_vaddr_i), .cpu_write_i(cpu_write_i),
    .cpu_user_i(cpu_user_i), .cpu_data_i(cpu_data_i), .cpu_ready_o(cpu_ready_o),
    .cpu_abort_o(cpu_abort_o), .cpu_paddr_o(cpu_paddr_o), .walk_req_o(walk_req_o),
    .walk_addr_o(walk_addr_o), .walk_ack_i(walk_ack_i), .walk_err_i(walk_err_i),
    .walk_rdata_i(walk_rdata_i), .cp_wr_i(cp_wr_i), .cp_rd_i(cp_rd_i), .cp_reg_i(cp_reg_i),
    .cp_wdata_i(cp_wdata_i), .cp_rdata_o(cp_rdata_o), .cp_rvalid_o(cp_rvalid_o));
